// *** rtl/ica_defines.svh ***
// Purpose: Constants for the interrupt-clear and reference override bank
// Assumes: AXI4-Lite, 32-bit data, printed offsets are word indexes
// Notes: Byte address is four times the register index
// What this block does
// - Writing one to a PLL-event ack bit clears that pending PLL event.
// - History/limit ack bits 4..0 clear their events; bits 7..5 reserved.
// - Reference ack: bits 6..4 second reference, 2..0 first; 7,3 reserved.
// - Phase control bit 2 zeroes the incremental phase offset, then clears.
// - Phase control bit 1 subtracts one step from the offset, self-clearing.
// - Phase control bit 0 adds one step to the offset, self-clearing.
// - Force bit 1 emulates second reference validation timeout, self-clearing.
// - Force bit 0 emulates first reference validation timeout, self-clearing.
// - Override bit 1 holds second reference invalid; resets to zero.
// - Override bit 0 holds first reference invalid; resets to zero.
// - Bypass bit 1 ignores second monitor, starts its validation timer.
// - Bypass bit 0 ignores first monitor, starts its validation timer.
// - Register after reference ack is wholly reserved, no function.
// - Ack bits self-clear and match the event monitor bit layout.
`ifndef ICA_DEFINES_SVH
`define ICA_DEFINES_SVH
`define ICA_IDX_PLL_ACK      12'ha06
`define ICA_IDX_HIST_ACK     12'ha07
`define ICA_IDX_REF_ACK      12'ha08
`define ICA_IDX_SPARE_ACK    12'ha09
`define ICA_IDX_PHASE_CTRL   12'ha0a
`define ICA_IDX_FORCE        12'ha0b
`define ICA_IDX_OVERRIDE     12'ha0c
`define ICA_IDX_BYPASS       12'ha0d
`define ICA_IDX_STEP         12'h312
`define ICA_IDX_OFFSET       12'he00
`define ICA_IDX_EVT_PLL      12'he01
`define ICA_IDX_EVT_HIST     12'he02
`define ICA_IDX_EVT_REF      12'he03
`define ICA_IDX_IRQ_STAT     12'he04
`define ICA_IDX_IRQ_MASK     12'he05
`define ICA_MASK_PLL         8'hff
`define ICA_MASK_HIST        8'h1f
`define ICA_MASK_REF         8'h77
`define ICA_MASK_PHASE       8'h07
`define ICA_MASK_TWO         8'h03
`define ICA_BIT_PH_RESET     2
`define ICA_BIT_PH_DEC       1
`define ICA_BIT_PH_INC       0
`define ICA_RESP_OKAY        2'h0
`define ICA_RESP_SLVERR      2'h2
`endif

// *** rtl/ica_pkg.sv ***
// Purpose: Types for the interrupt-clear and reference override bank
// Assumes: Used as ica_pkg::name only
// Notes: Per-reference signals bundled as structs
package ica_pkg;
  typedef struct packed {
    logic second;
    logic first;
  } ica_ref_pair_t;
  typedef struct packed {
    ica_ref_pair_t force_valid;
    ica_ref_pair_t hold_invalid;
    ica_ref_pair_t bypass;
  } ica_ref_ctrl_t;
  typedef enum logic [1:0] {
    ICA_RD_IDLE = 2'b00,
    ICA_RD_RESP = 2'b01
  } ica_rd_state_t;
endpackage : ica_pkg

// *** rtl/ica_bank.sv ***
// Purpose: Interrupt acknowledge and reference override register bank
// Assumes: Single 250 MHz clock, async active-high reset, AXI4-Lite slave
// Notes: Pending events live here; event monitors pulse the set inputs
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ica_defines.svh"
module ica_bank #(
  parameter int OFFSET_W = 32
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic [13:0]           s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [13:0]           s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  output logic                       s_axi_rready_unused_out,
  input  wire logic                  s_axi_rready_in,
  input  wire logic [7:0]            pll_event_set_in,
  input  wire logic [7:0]            hist_event_set_in,
  input  wire logic [7:0]            ref_event_set_in,
  output logic [7:0]                 pll_event_pending_out,
  output logic [7:0]                 hist_event_pending_out,
  output logic [7:0]                 ref_event_pending_out,
  output logic [OFFSET_W-1:0]        phase_offset_out,
  output ica_pkg::ica_ref_ctrl_t     ref_ctrl_out,
  output logic                       irq_out
);

  logic                   aw_held;
  logic                   w_held;
  logic [11:0]            aw_idx;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic                   wr_hit;
  logic                   lo_en;
  logic [7:0]             wb;
  logic [15:0]            step_size;

  logic [7:0]             phase_pulse;
  logic [1:0]             force_pulse;
  logic [1:0]             override_reg;
  logic [1:0]             bypass_reg;

  logic [7:0]             pll_pend;
  logic [7:0]             hist_pend;
  logic [7:0]             ref_pend;
  logic [OFFSET_W-1:0]    offset_acc;

  logic [2:0]             irq_stat;
  logic [2:0]             irq_mask;
  logic [2:0]             irq_evt;

  ica_pkg::ica_rd_state_t rd_state;
  logic [31:0]            next_rdata;
  logic                   next_rmiss;
  logic [11:0]            ar_idx;

  logic                   sel_pll_ack;
  logic                   sel_hist_ack;
  logic                   sel_ref_ack;
  logic                   sel_phase;
  logic                   sel_force;
  logic                   sel_override;
  logic                   sel_bypass;
  logic                   sel_irq_stat;
  logic                   sel_irq_mask;
  logic                   sel_step;
  logic [7:0]             pll_clr;
  logic [7:0]             hist_clr;
  logic [7:0]             ref_clr;
  logic [2:0]             irq_clr;

  // Write channel capture, either order
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
  assign s_axi_rready_unused_out = 1'b0;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_idx <= 12'h000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_idx <= s_axi_awaddr_in[13:2];
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      w_held <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end
  end

  assign wr_fire = aw_held && w_held;
  assign lo_en   = wr_fire && w_strb[0];
  assign wb      = w_data[7:0];

  // Decoded write selects
  assign sel_pll_ack  = lo_en && (aw_idx == `ICA_IDX_PLL_ACK);
  assign sel_hist_ack = lo_en && (aw_idx == `ICA_IDX_HIST_ACK);
  assign sel_ref_ack  = lo_en && (aw_idx == `ICA_IDX_REF_ACK);
  assign sel_phase    = lo_en && (aw_idx == `ICA_IDX_PHASE_CTRL);
  assign sel_force    = lo_en && (aw_idx == `ICA_IDX_FORCE);
  assign sel_override = lo_en && (aw_idx == `ICA_IDX_OVERRIDE);
  assign sel_bypass   = lo_en && (aw_idx == `ICA_IDX_BYPASS);
  assign sel_irq_stat = lo_en && (aw_idx == `ICA_IDX_IRQ_STAT);
  assign sel_irq_mask = lo_en && (aw_idx == `ICA_IDX_IRQ_MASK);
  assign sel_step     = wr_fire && (aw_idx == `ICA_IDX_STEP);

  // Clear masks from acknowledge writes
  assign pll_clr  = sel_pll_ack ? wb : 8'h00;
  assign hist_clr = sel_hist_ack ? wb : 8'h00;
  assign ref_clr  = sel_ref_ack ? wb : 8'h00;
  assign irq_clr  = sel_irq_stat ? wb[2:0] : 3'b000;

  always_comb begin
    case (aw_idx)
      `ICA_IDX_PLL_ACK, `ICA_IDX_HIST_ACK, `ICA_IDX_REF_ACK,
      `ICA_IDX_SPARE_ACK, `ICA_IDX_PHASE_CTRL, `ICA_IDX_FORCE,
      `ICA_IDX_OVERRIDE, `ICA_IDX_BYPASS, `ICA_IDX_STEP,
      `ICA_IDX_IRQ_STAT, `ICA_IDX_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_bresp_out <= `ICA_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp_out <= wr_hit ? `ICA_RESP_OKAY : `ICA_RESP_SLVERR;
    end
  end

  // Step size, two bytes in one word
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      step_size <= 16'h0000;
    end else if (sel_step) begin
      if (w_strb[0]) begin
        step_size[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        step_size[15:8] <= w_data[15:8];
      end
    end
  end

  // Single-cycle action pulses; zero bits do nothing
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_pulse <= 8'h00;
    end else if (sel_phase) begin
      phase_pulse <= wb & `ICA_MASK_PHASE;
    end else begin
      phase_pulse <= 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      force_pulse <= 2'b00;
    end else if (sel_force) begin
      force_pulse <= wb[1:0];
    end else begin
      force_pulse <= 2'b00;
    end
  end

  // Incremental phase offset; reset wins, then dec, then inc
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      offset_acc <= '0;
    end else if (phase_pulse[`ICA_BIT_PH_RESET]) begin
      offset_acc <= '0;
    end else if (phase_pulse[`ICA_BIT_PH_DEC]) begin
      offset_acc <= offset_acc - OFFSET_W'(step_size);
    end else if (phase_pulse[`ICA_BIT_PH_INC]) begin
      offset_acc <= offset_acc + OFFSET_W'(step_size);
    end
  end

  // Override and bypass levels
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      override_reg <= 2'b00;
    end else if (sel_override) begin
      override_reg <= wb[1:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bypass_reg <= 2'b00;
    end else if (sel_bypass) begin
      bypass_reg <= wb[1:0];
    end
  end

  assign ref_ctrl_out.force_valid.second  = force_pulse[1];
  assign ref_ctrl_out.force_valid.first   = force_pulse[0];
  assign ref_ctrl_out.hold_invalid.second = override_reg[1];
  assign ref_ctrl_out.hold_invalid.first  = override_reg[0];
  assign ref_ctrl_out.bypass.second       = bypass_reg[1];
  assign ref_ctrl_out.bypass.first        = bypass_reg[0];
  assign phase_offset_out = offset_acc;

  // Pending events: set wins over ack clear
  localparam logic [7:0] PLL_KEEP  = `ICA_MASK_PLL;
  localparam logic [7:0] HIST_KEEP = `ICA_MASK_HIST;
  localparam logic [7:0] REF_KEEP  = `ICA_MASK_REF;

  for (genvar g = 0; g < 8; g++) begin : g_pend
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        pll_pend[g]  <= 1'b0;
        hist_pend[g] <= 1'b0;
        ref_pend[g]  <= 1'b0;
      end else begin
        pll_pend[g] <= PLL_KEEP[g]
                       & ((pll_pend[g] & ~pll_clr[g])
                       | pll_event_set_in[g]);
        hist_pend[g] <= HIST_KEEP[g]
                        & ((hist_pend[g] & ~hist_clr[g])
                        | hist_event_set_in[g]);
        ref_pend[g] <= REF_KEEP[g]
                       & ((ref_pend[g] & ~ref_clr[g])
                       | ref_event_set_in[g]);
      end
    end
  end

  assign pll_event_pending_out  = pll_pend;
  assign hist_event_pending_out = hist_pend;
  assign ref_event_pending_out  = ref_pend;

  // Interrupt status per group, sticky, write one to clear
  assign irq_evt = {|ref_event_set_in, |hist_event_set_in,
                    |pll_event_set_in};

  for (genvar k = 0; k < 3; k++) begin : g_irq
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        irq_stat[k] <= 1'b0;
      end else begin
        irq_stat[k] <= (irq_stat[k] & ~irq_clr[k]) | irq_evt[k];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask <= 3'b000;
    end else if (sel_irq_mask) begin
      irq_mask <= wb[2:0];
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // Read path; ack, pulse and reserved registers read zero
  assign ar_idx = s_axi_araddr_in[13:2];
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rmiss = 1'b0;
    case (ar_idx)
      `ICA_IDX_PLL_ACK, `ICA_IDX_HIST_ACK, `ICA_IDX_REF_ACK,
      `ICA_IDX_PHASE_CTRL, `ICA_IDX_FORCE: begin
        next_rdata = 32'h0000_0000;
      end
      `ICA_IDX_SPARE_ACK: begin
        next_rdata = 32'h0000_0000;
      end
      `ICA_IDX_OVERRIDE: next_rdata = {30'h0, override_reg};
      `ICA_IDX_BYPASS:   next_rdata = {30'h0, bypass_reg};
      `ICA_IDX_STEP:     next_rdata = {16'h0, step_size};
      `ICA_IDX_OFFSET:   next_rdata = 32'(offset_acc);
      `ICA_IDX_EVT_PLL:  next_rdata = {24'h0, pll_pend};
      `ICA_IDX_EVT_HIST: next_rdata = {24'h0, hist_pend};
      `ICA_IDX_EVT_REF:  next_rdata = {24'h0, ref_pend};
      `ICA_IDX_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `ICA_IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      default:           next_rmiss = 1'b1;
    endcase
  end

  assign s_axi_arready_out = (rd_state == ica_pkg::ICA_RD_IDLE);

  // Read data captured as the address is taken
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `ICA_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rmiss ? `ICA_RESP_SLVERR
                                    : `ICA_RESP_OKAY;
    end
  end

  // Read response state
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_state         <= ica_pkg::ICA_RD_IDLE;
      s_axi_rvalid_out <= 1'b0;
    end else begin
      case (rd_state)
        ica_pkg::ICA_RD_IDLE: begin
          if (s_axi_arvalid_in) begin
            rd_state         <= ica_pkg::ICA_RD_RESP;
            s_axi_rvalid_out <= 1'b1;
          end
        end
        ica_pkg::ICA_RD_RESP: begin
          if (s_axi_rready_in) begin
            rd_state         <= ica_pkg::ICA_RD_IDLE;
            s_axi_rvalid_out <= 1'b0;
          end
        end
        default: begin
          rd_state         <= ica_pkg::ICA_RD_IDLE;
          s_axi_rvalid_out <= 1'b0;
        end
      endcase
    end
  end

endmodule : ica_bank

// *** verif/ica_bank_asserts.sv ***
// Purpose: Port checks for the acknowledge and override bank
// Assumes: Byte address is four times the register index
// Notes: Bound to ica_bank at the foot of this file
`timescale 1ns/100ps
module ica_bank_asserts #(
  parameter int OFFSET_W = 32
) (
  input wire logic                   core_clk_in,
  input wire logic                   sys_rst_in,
  input wire logic [13:0]            s_axi_awaddr_in,
  input wire logic                   s_axi_awvalid_in,
  input wire logic                   s_axi_awready_out,
  input wire logic [31:0]            s_axi_wdata_in,
  input wire logic                   s_axi_wvalid_in,
  input wire logic                   s_axi_wready_out,
  input wire logic                   s_axi_bvalid_out,
  input wire logic [7:0]             pll_event_set_in,
  input wire logic [7:0]             hist_event_set_in,
  input wire logic [7:0]             ref_event_set_in,
  input wire logic [7:0]             pll_event_pending_out,
  input wire logic [7:0]             hist_event_pending_out,
  input wire logic [7:0]             ref_event_pending_out,
  input wire logic [OFFSET_W-1:0]    phase_offset_out,
  input wire ica_pkg::ica_ref_ctrl_t ref_ctrl_out
);
  logic [13:0] wa;
  logic [7:0]  wd;
  // Last write address and data byte
  always_ff @(posedge core_clk_in) begin
    if (s_axi_awvalid_in && s_axi_awready_out) wa <= s_axi_awaddr_in;
    if (s_axi_wvalid_in && s_axi_wready_out) wd <= s_axi_wdata_in[7:0];
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pll_clear: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h2818 &&
    ($past(pll_event_set_in) | $past(pll_event_set_in, 2)) == 8'h00
    |-> (pll_event_pending_out & wd) == 8'h00)
    else $error("pll ack left an event pending");
  a_hist_clear: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h281c &&
    ($past(hist_event_set_in) | $past(hist_event_set_in, 2)) == 8'h00
    |-> (hist_event_pending_out & wd & 8'h1f) == 8'h00)
    else $error("hist ack left an event pending");
  a_ref_clear: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h2820 &&
    ($past(ref_event_set_in) | $past(ref_event_set_in, 2)) == 8'h00
    |-> (ref_event_pending_out & wd & 8'h77) == 8'h00)
    else $error("ref ack left an event pending");
  a_phase_zero: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h2828 && wd[2]
    |-> ##[0:3] phase_offset_out == '0)
    else $error("phase offset not zeroed");
  a_force_once: assert property (
    ref_ctrl_out.force_valid != 2'b00 |=> ref_ctrl_out.force_valid == 2'b00)
    else $error("force pulse longer than one cycle");
  a_force_cause: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h282c
    |-> ##[0:2] ref_ctrl_out.force_valid == wd[1:0])
    else $error("force pulse does not follow write");
  a_hold_level: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h2830
    |-> ##[0:2] ref_ctrl_out.hold_invalid == wd[1:0])
    else $error("override level wrong");
  a_hold_steady: assert property (
    !$stable(ref_ctrl_out.hold_invalid) |-> wa == 14'h2830)
    else $error("override changed without write");
  a_bypass_level: assert property (
    $rose(s_axi_bvalid_out) && wa == 14'h2834
    |-> ##[0:2] ref_ctrl_out.bypass == wd[1:0])
    else $error("bypass level wrong");
endmodule : ica_bank_asserts

bind ica_bank ica_bank_asserts #(.OFFSET_W(OFFSET_W)) chk_u (.*);

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the acknowledge and override bank
// Assumes: Reads answer in order; effects land before the next access
// Notes: Reads queue expected data; a monitor compares
`timescale 1ns/100ps
module tb;
  logic        clk, rst, aw, w, b, ar, rr;
  logic [13:0] aa, ra;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [1:0]  lb;
  logic [7:0]  es [3];
  wire logic   awr, wrr, bv, arr, rv, irq;
  wire logic [1:0]  br, rs;
  wire logic [31:0] rd, off;
  wire logic [7:0]  pd [3];
  wire ica_pkg::ica_ref_ctrl_t rc;
  logic [33:0] q [$];
  int n_errors, checked;
  ica_bank dut_u (.core_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(aa), .s_axi_awvalid_in(aw), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(w),
    .s_axi_wready_out(wrr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(b), .s_axi_araddr_in(ra), .s_axi_arvalid_in(ar),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rs),
    .s_axi_rvalid_out(rv), .s_axi_rready_unused_out(), .s_axi_rready_in(rr),
    .pll_event_set_in(es[0]), .hist_event_set_in(es[1]),
    .ref_event_set_in(es[2]), .pll_event_pending_out(pd[0]),
    .hist_event_pending_out(pd[1]), .ref_event_pending_out(pd[2]),
    .phase_offset_out(off), .ref_ctrl_out(rc), .irq_out(irq));
  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [33:0] ok(input logic [31:0] v);
    return {2'h0, v};
  endfunction : ok
  task automatic wt(input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    aa <= a;
    wd <= d;
    aw <= 1'b1;
    w <= 1'b1;
    b <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) aw <= 1'b0;
      if (wrr) w <= 1'b0;
      n++;
    end while (!bv && n < 100);
    lb = br;
    b <= 1'b0;
    @(posedge clk);
  endtask : wt
  task automatic rt(input logic [13:0] a, input logic [33:0] e);
    int n;
    n = 0;
    q.push_back(e);
    ra <= a;
    ar <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) ar <= 1'b0;
      n++;
    end while (!rv && n < 100);
    rr <= 1'b0;
    @(posedge clk);
  endtask : rt
  // Read data monitor
  always @(posedge clk)
    if (rv && rr && q.size() > 0) chk({rs, rd}, q.pop_front());
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    logic [7:0]  r, c, mk [3];
    logic [15:0] s;
    int          i;
    {rst, aw, w, b, ar, rr, aa, ra, wd, ws} = {1'b1, 86'h0};
    {es[0], es[1], es[2]} = 24'h0;
    mk[0] = 8'hff;
    mk[1] = 8'h1f;
    mk[2] = 8'h77;
    void'($urandom(32'h42a09263));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ws <= 4'hf;
    @(posedge clk);
    for (i = 0; i < 8; i++) rt(14'h2818 + 14'(4 * i), 34'h0);
    for (i = 0; i < 3; i++) begin
      r = 8'($urandom) | 8'h01;
      c = 8'($urandom) & 8'hfe;
      es[i] <= r;
      @(posedge clk);
      es[i] <= 8'h00;
      @(posedge clk);
      rt(14'h3804 + 14'(4 * i), ok(r & mk[i]));
      wt(14'h2818 + 14'(4 * i), {24'($urandom), c});
      rt(14'h3804 + 14'(4 * i), ok(r & mk[i] & ~c));
      wt(14'h2818 + 14'(4 * i), 32'hff);
      rt(14'h3804 + 14'(4 * i), ok(32'h0));
    end
    chk(34'(irq), 34'h0);
    rt(14'h3810, ok(32'h7));
    wt(14'h3814, 32'h2);
    chk(34'(irq), 34'h1);
    wt(14'h3810, 32'h2);
    chk(34'(irq), 34'h0);
    rt(14'h3810, ok(32'h5));
    s = 16'($urandom) | 16'h1;
    wt(14'h0c48, {16'h0, s});
    repeat (2) wt(14'h2828, 32'h1);
    wt(14'h2828, 32'h2);
    wt(14'h2828, 32'hfffffff8);
    rt(14'h3800, ok(32'(s)));
    chk(34'(off), 34'(s));
    repeat (2) wt(14'h2828, 32'h2);
    rt(14'h3800, ok(-32'(s)));
    chk(34'(off), ok(-32'(s)));
    wt(14'h2828, 32'h7);
    rt(14'h3800, ok(32'h0));
    for (i = 0; i < 2; i++) begin
      wt(14'h2834, 32'(1 << i));
      wt(14'h282c, 32'(1 << i));
      chk(34'(rc), 34'(1 << i));
    end
    wt(14'h2830, 32'hfffffff3);
    chk(34'(rc), 34'h0e);
    rt(14'h2830, ok(32'h3));
    rt(14'h2834, ok(32'h2));
    rt(14'h282c, ok(32'h0));
    wt(14'h3ffc, 32'h0);
    chk(34'(lb), 34'h2);
    rt(14'h3ffc, 34'h200000000);
    rt(14'h2830, ok(32'h3));
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rt(14'h2830, ok(32'h0));
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule : tb
